// ---- pkg/pds_pkg.sv ----
// constants and carrier types for paged data space address generation
package pds_pkg;

    // ----------------
    // register map (byte offsets on apb)
    // ----------------
    localparam logic [7:0]  PDS_OFS_PAGE   = 8'h00;
    localparam logic [7:0]  PDS_OFS_SP     = 8'h04;
    localparam logic [7:0]  PDS_OFS_FP     = 8'h08;
    localparam logic [7:0]  PDS_OFS_CTRL   = 8'h0c;
    localparam logic [7:0]  PDS_OFS_STATUS = 8'h10;

    // ----------------
    // field positions and reset values
    // ----------------
    localparam int          PDS_CTRL_FPA_BIT    = 0;
    localparam int          PDS_STAT_TRAP_BIT   = 0;
    localparam int          PDS_STAT_PSWR_BIT   = 1;
    localparam int          PDS_STAT_CNT_LSB    = 8;
    localparam int          PDS_PAGE_PS_BIT     = 9;
    localparam logic [9:0]  PDS_PAGE_RESET      = 10'h001;
    localparam logic [15:0] PDS_SP_RESET        = 16'h1000;
    localparam logic [15:0] PDS_FP_RESET        = 16'h0000;

    // ----------------
    // page boundary values and stack step
    // ----------------
    localparam logic [9:0]  PDS_PAGE_ZERO       = 10'h000;
    localparam logic [9:0]  PDS_PAGE_FIRST      = 10'h001;
    localparam logic [9:0]  PDS_PAGE_PS_FIRST   = 10'h200;
    localparam logic [9:0]  PDS_PAGE_PS_LAST    = 10'h3ff;
    localparam logic [15:0] PDS_STACK_STEP      = 16'h0002;

    // ----------------
    // addressing modes, stack commands and stack states (one-hot)
    // ----------------
    typedef enum logic [5:0] {
        PDS_MODE_PLAIN   = 6'b000001,
        PDS_MODE_PRE     = 6'b000010,
        PDS_MODE_POST    = 6'b000100,
        PDS_MODE_REGOFS  = 6'b001000,
        PDS_MODE_MODULO  = 6'b010000,
        PDS_MODE_BITREV  = 6'b100000
    } pds_mode_e;

    typedef enum logic [3:0] {
        PDS_STK_NONE     = 4'b0001,
        PDS_STK_CALL     = 4'b0010,
        PDS_STK_EXC      = 4'b0100,
        PDS_STK_POP      = 4'b1000
    } pds_stk_e;

    typedef enum logic [1:0] {
        PDS_ST_IDLE      = 2'b01,
        PDS_ST_PUSH_HI   = 2'b10
    } pds_state_e;

    // ----------------
    // carriers
    // ----------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        stack_ptr;
        pds_mode_e   mode;
        logic [15:0] base;
        logic [15:0] offset;
    } pds_req_s;

    typedef struct packed {
        logic        valid;
        logic        addr_err;
        logic        prog_space;
        logic [23:0] addr;
        logic [15:0] new_ptr;
    } pds_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] data;
    } pds_stk_wr_s;

endpackage : pds_pkg

// ---- verilog/pds_addr_gen.sv ----
// paged data space address generator with stack pointer logic
//
// Functional notes
// - page bits 8:0 and ea bits 14:0 give 24-bit address
// - pages 0x200 up map program space, reads only
// - upper half access with page zero traps
// - page carry only for pre/post modified pointers
// - overflow increments, underflow decrements page, ea15 set
// - offset/modulo/bitrev carry wraps within current page
// - 0x2ff and 0x300 step across, ea15 stays
// - 0x3ff overflow, 0x001/0x200 underflow clear ea15
// - lower half always reaches base data space
// - page register resets to 0x001
// - software clear of page has no effect
// - nonzero pages only through upper address half
// - stack pointer bit0 always zero
// - stack pointer resets to 0x1000
// - stack grows up, post-inc push, pre-dec pop
// - pc low word first, then zero-extended high
// - exception push carries status low byte
// - stack pointer never paged, active frame pointer paged like any other pointer
// - stack pointer auto-updated yet software accessible
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pds_addr_gen #(
    parameter int APB_AW = 8
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [APB_AW-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // cpu address request
    input  wire pds_pkg::pds_req_s    agu_req,
    output pds_pkg::pds_rsp_s         agu_rsp,
    // cpu stack port
    input  wire pds_pkg::pds_stk_e    stk_cmd,
    input  wire logic [22:0]          pc_value,
    input  wire logic [7:0]           status_low_byte,
    input  wire logic                 sp_wr_en,
    input  wire logic [15:0]          sp_wr_data,
    input  wire logic                 fp_wr_en,
    input  wire logic [15:0]          fp_wr_data,
    output pds_pkg::pds_stk_wr_s      stk_wr,
    output logic                      stk_busy,
    output logic      [15:0]          pop_addr,
    output logic      [15:0]          stack_pointer_reg,
    output logic      [15:0]          frame_pointer_reg,
    output logic      [9:0]           data_read_page_reg,
    output logic                      frame_pointer_active
);
    import pds_pkg::*;

    // ----------------
    // parameter check
    // ----------------
    generate
        if (APB_AW < 5 || APB_AW > 16) begin : g_bad_aw
            $error("pds_addr_gen: APB_AW must be 5 to 16");
        end
    endgenerate

    // ----------------
    // state
    // ----------------
    typedef struct packed {
        pds_state_e  state;
        logic [9:0]  page;
        logic [15:0] sp;
        logic [15:0] fp;
        logic        fpa;
        logic        trap_flag;
        logic        pswr_flag;
        logic [7:0]  trap_cnt;
        logic [15:0] hi_word;
        logic [31:0] rdata;
        pds_rsp_s    rsp;
        pds_stk_wr_s stk;
    } pds_st_s;

    pds_st_s st_r;
    pds_st_s st_nxt;

    // ----------------
    // address arithmetic
    // ----------------
    logic [16:0] sum17;
    logic        ptr_paged;
    logic        ovf;
    logic        unf;
    logic        linear_mode;
    logic        wrap_mode;
    logic [15:0] ea_mod;
    logic [9:0]  page_mod;
    logic [15:0] ea_acc;
    logic [9:0]  page_acc;

    always_comb begin
        sum17       = {1'b0, agu_req.base} + {agu_req.offset[15], agu_req.offset};
        ptr_paged   = !(agu_req.stack_ptr || agu_req.base == st_r.sp);
        linear_mode = (agu_req.mode == PDS_MODE_PRE) || (agu_req.mode == PDS_MODE_POST);
        wrap_mode   = (agu_req.mode == PDS_MODE_REGOFS) || (agu_req.mode == PDS_MODE_MODULO)
                      || (agu_req.mode == PDS_MODE_BITREV);
        ovf         = ptr_paged && agu_req.base[15] && !agu_req.offset[15] && sum17[16];
        unf         = ptr_paged && agu_req.base[15] && agu_req.offset[15] && !sum17[15];
        ea_mod      = sum17[15:0];
        page_mod    = st_r.page;
        if (agu_req.mode == PDS_MODE_PLAIN) begin
            ea_mod = agu_req.base;
        end else if (linear_mode && ovf) begin
            if (st_r.page == PDS_PAGE_PS_LAST) begin
                ea_mod[15] = 1'b0;
            end else begin
                page_mod   = st_r.page + 10'h001;
                ea_mod[15] = 1'b1;
            end
        end else if (linear_mode && unf) begin
            if (st_r.page == PDS_PAGE_FIRST || st_r.page == PDS_PAGE_PS_FIRST) begin
                ea_mod[15] = 1'b0;
            end else begin
                page_mod   = st_r.page - 10'h001;
                ea_mod[15] = 1'b1;
            end
        end else if (wrap_mode && (ovf || unf)) begin
            ea_mod[15] = 1'b1;
        end
        if (agu_req.mode == PDS_MODE_POST) begin
            ea_acc   = agu_req.base;
            page_acc = st_r.page;
        end else begin
            ea_acc   = ea_mod;
            page_acc = page_mod;
        end
    end

    // ----------------
    // apb decode
    // ----------------
    logic        apb_acc;
    logic        apb_wr;
    logic        apb_hit;
    logic [7:0]  apb_ofs;
    logic [31:0] apb_rd;

    always_comb begin
        apb_acc = psel && penable;
        apb_wr  = apb_acc && pwrite;
        apb_ofs = 8'(paddr);
        apb_hit = 1'b1;
        apb_rd  = 32'h0000_0000;
        if (apb_ofs == PDS_OFS_PAGE) begin
            apb_rd = {22'h000000, st_r.page};
        end else if (apb_ofs == PDS_OFS_SP) begin
            apb_rd = {16'h0000, st_r.sp};
        end else if (apb_ofs == PDS_OFS_FP) begin
            apb_rd = {16'h0000, st_r.fp};
        end else if (apb_ofs == PDS_OFS_CTRL) begin
            apb_rd[PDS_CTRL_FPA_BIT] = st_r.fpa;
        end else if (apb_ofs == PDS_OFS_STATUS) begin
            apb_rd[PDS_STAT_TRAP_BIT]               = st_r.trap_flag;
            apb_rd[PDS_STAT_PSWR_BIT]               = st_r.pswr_flag;
            apb_rd[PDS_STAT_CNT_LSB +: 8]           = st_r.trap_cnt;
        end else begin
            apb_hit = 1'b0;
        end
        if (APB_AW > 8 && paddr != APB_AW'(apb_ofs)) begin
            apb_hit = 1'b0;
            apb_rd  = 32'h0000_0000;
        end
    end

    // ----------------
    // next state
    // ----------------
    logic trap_evt;
    logic pswr_evt;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.rsp.valid = 1'b0;
        st_nxt.stk.valid = 1'b0;
        trap_evt         = 1'b0;
        pswr_evt         = 1'b0;

        // software register access
        if (psel && !penable && !pwrite) begin
            st_nxt.rdata = apb_rd;
        end
        if (apb_wr && apb_hit) begin
            if (apb_ofs == PDS_OFS_PAGE) begin
                if (pwdata[9:0] != PDS_PAGE_ZERO) begin
                    st_nxt.page = pwdata[9:0];
                end
            end else if (apb_ofs == PDS_OFS_SP) begin
                st_nxt.sp = {pwdata[15:1], 1'b0};
            end else if (apb_ofs == PDS_OFS_FP) begin
                st_nxt.fp = pwdata[15:0];
            end else if (apb_ofs == PDS_OFS_CTRL) begin
                st_nxt.fpa = pwdata[PDS_CTRL_FPA_BIT];
            end else if (apb_ofs == PDS_OFS_STATUS) begin
                if (pwdata[PDS_STAT_TRAP_BIT]) begin
                    st_nxt.trap_flag = 1'b0;
                end
                if (pwdata[PDS_STAT_PSWR_BIT]) begin
                    st_nxt.pswr_flag = 1'b0;
                end
            end
        end

        // instruction access to pointer registers
        if (fp_wr_en) begin
            st_nxt.fp = fp_wr_data;
        end
        if (sp_wr_en) begin
            st_nxt.sp = {sp_wr_data[15:1], 1'b0};
        end

        // address generation
        if (agu_req.valid) begin
            st_nxt.rsp.valid      = 1'b1;
            st_nxt.rsp.addr_err   = 1'b0;
            st_nxt.rsp.prog_space = 1'b0;
            st_nxt.rsp.new_ptr    = ea_mod;
            if (!ptr_paged || !ea_acc[15]) begin
                st_nxt.rsp.addr = {8'h00, ea_acc};
            end else if (page_acc == PDS_PAGE_ZERO) begin
                st_nxt.rsp.addr     = {8'h00, ea_acc};
                st_nxt.rsp.addr_err = 1'b1;
                trap_evt            = 1'b1;
            end else if (page_acc[PDS_PAGE_PS_BIT]) begin
                st_nxt.rsp.addr       = {page_acc[8:0], ea_acc[14:0]};
                st_nxt.rsp.prog_space = 1'b1;
                if (agu_req.write) begin
                    st_nxt.rsp.addr_err = 1'b1;
                    pswr_evt            = 1'b1;
                end
            end else begin
                st_nxt.rsp.addr = {page_acc[8:0], ea_acc[14:0]};
            end
            if (ptr_paged && !(st_nxt.rsp.addr_err)) begin
                st_nxt.page = page_mod;
            end
        end

        // stack machine
        case (st_r.state)
            PDS_ST_IDLE: begin
                if (stk_cmd == PDS_STK_CALL || stk_cmd == PDS_STK_EXC) begin
                    st_nxt.stk.valid = 1'b1;
                    st_nxt.stk.addr  = st_r.sp;
                    st_nxt.stk.data  = pc_value[15:0];
                    st_nxt.sp        = st_r.sp + PDS_STACK_STEP;
                    if (stk_cmd == PDS_STK_EXC) begin
                        st_nxt.hi_word = {status_low_byte, 1'b0, pc_value[22:16]};
                    end else begin
                        st_nxt.hi_word = {8'h00, 1'b0, pc_value[22:16]};
                    end
                    st_nxt.state = PDS_ST_PUSH_HI;
                end else if (stk_cmd == PDS_STK_POP) begin
                    st_nxt.sp = st_r.sp - PDS_STACK_STEP;
                end
            end
            PDS_ST_PUSH_HI: begin
                st_nxt.stk.valid = 1'b1;
                st_nxt.stk.addr  = st_r.sp;
                st_nxt.stk.data  = st_r.hi_word;
                st_nxt.sp        = st_r.sp + PDS_STACK_STEP;
                st_nxt.state     = PDS_ST_IDLE;
            end
            default: begin
                st_nxt.state = PDS_ST_IDLE;
            end
        endcase
        st_nxt.sp[0] = 1'b0;

        // sticky flags, set wins over clear
        if (trap_evt) begin
            st_nxt.trap_flag = 1'b1;
            st_nxt.trap_cnt  = st_r.trap_cnt + 8'h01;
        end
        if (pswr_evt) begin
            st_nxt.pswr_flag = 1'b1;
        end
    end

    // ----------------
    // registers
    // ----------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r           <= '0;
            st_r.state     <= PDS_ST_IDLE;
            st_r.page      <= PDS_PAGE_RESET;
            st_r.sp        <= PDS_SP_RESET;
            st_r.fp        <= PDS_FP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------
    // outputs
    // ----------------
    always_comb begin
        pready               = 1'b1;
        pslverr              = psel && penable && !apb_hit;
        prdata               = st_r.rdata;
        agu_rsp              = st_r.rsp;
        stk_wr               = st_r.stk;
        stk_busy             = (st_r.state == PDS_ST_PUSH_HI);
        pop_addr             = st_r.sp - PDS_STACK_STEP;
        stack_pointer_reg    = st_r.sp;
        frame_pointer_reg    = st_r.fp;
        data_read_page_reg   = st_r.page;
        frame_pointer_active = st_r.fpa;
    end

endmodule : pds_addr_gen

`default_nettype wire

// ---- verif/pds_mem_model.sv ----
// stack memory model on the cpu data bus side
`timescale 1ns/1ps
`default_nettype none

module pds_mem_model (
    input wire logic                 sys_clk,
    input wire pds_pkg::pds_stk_wr_s stk_wr
);
    import pds_pkg::*;

    // unwritten words stay unknown so a missing push never matches
    logic [15:0] mem [0:65535];

    always_ff @(posedge sys_clk) begin
        if (stk_wr.valid) begin
            mem[stk_wr.addr] <= stk_wr.data;
        end
    end
endmodule : pds_mem_model

`default_nettype wire

// ---- verif/pds_addr_gen_props.sv ----
// concurrent checks on the address generator ports
`timescale 1ns/1ps
`default_nettype none

module pds_addr_gen_chk (
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire pds_pkg::pds_req_s    agu_req,
    input wire pds_pkg::pds_rsp_s    agu_rsp,
    input wire pds_pkg::pds_stk_e    stk_cmd,
    input wire logic [22:0]          pc_value,
    input wire logic [7:0]           status_low_byte,
    input wire logic                 sp_wr_en,
    input wire logic [15:0]          sp_wr_data,
    input wire pds_pkg::pds_stk_wr_s stk_wr,
    input wire logic                 stk_busy,
    input wire logic [15:0]          stack_pointer_reg,
    input wire logic [9:0]           data_read_page_reg
);
    import pds_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [15:0] req_base;
    logic [15:0] pc_lo;
    logic [6:0]  pc_hi;
    logic [23:0] prog_addr;
    logic        paged_req;
    assign req_base  = agu_req.base;
    assign pc_lo     = pc_value[15:0];
    assign pc_hi     = pc_value[22:16];
    assign prog_addr = {data_read_page_reg[8:0], agu_req.base[14:0]};
    assign paged_req = agu_req.valid && !agu_req.stack_ptr && agu_req.base[15]
                       && agu_req.mode == PDS_MODE_PLAIN && agu_req.base != stack_pointer_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_push_lo;
        stk_wr.valid && stk_wr.addr == $past(stack_pointer_reg) && stk_wr.data == $past(pc_lo);
    endsequence
    sequence s_push_hi;
        stk_wr.valid && stk_wr.addr == $past(stack_pointer_reg, 2) + PDS_STACK_STEP
        && stk_wr.data[7:0] == {1'b0, $past(pc_hi, 2)};
    endsequence

    property p_sp_even;
        stack_pointer_reg[0] == 1'b0;
    endproperty
    a_sp_even: assert property (p_sp_even) else $error("odd stack pointer");

    property p_page_nonzero;
        data_read_page_reg != PDS_PAGE_ZERO;
    endproperty
    a_page_nonzero: assert property (p_page_nonzero) else $error("page zero");

    property p_reset_vals;
        disable iff (1'b0) reset |=> data_read_page_reg == PDS_PAGE_RESET
            && stack_pointer_reg == PDS_SP_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value");

    property p_prog_read;
        paged_req && !agu_req.write && data_read_page_reg[9]
            |=> agu_rsp.valid && agu_rsp.prog_space && agu_rsp.addr == $past(prog_addr);
    endproperty
    a_prog_read: assert property (p_prog_read) else $error("program read address");

    property p_prog_write;
        paged_req && agu_req.write && data_read_page_reg[9]
            |=> agu_rsp.addr_err && data_read_page_reg == $past(data_read_page_reg);
    endproperty
    a_prog_write: assert property (p_prog_write) else $error("program write allowed");

    property p_low_half;
        agu_req.valid && !agu_req.base[15] && agu_req.mode == PDS_MODE_PLAIN && !agu_req.write
            |=> !agu_rsp.addr_err && agu_rsp.addr == {8'h00, $past(req_base)};
    endproperty
    a_low_half: assert property (p_low_half) else $error("lower half address");

    property p_unpaged;
        agu_req.valid && agu_req.stack_ptr
            && (agu_req.mode == PDS_MODE_PLAIN || agu_req.mode == PDS_MODE_POST)
            |=> !agu_rsp.prog_space && agu_rsp.addr == {8'h00, $past(req_base)};
    endproperty
    a_unpaged: assert property (p_unpaged) else $error("stack pointer paged");

    property p_call;
        stk_cmd == PDS_STK_CALL && !stk_busy
            |=> s_push_lo ##1 (s_push_hi ##0 stk_wr.data[15:8] == 8'h00);
    endproperty
    a_call: assert property (p_call) else $error("call push frame");

    property p_exc;
        stk_cmd == PDS_STK_EXC && !stk_busy
            |=> s_push_lo ##1 (s_push_hi ##0 stk_wr.data[15:8] == $past(status_low_byte, 2));
    endproperty
    a_exc: assert property (p_exc) else $error("exception push frame");

    property p_pop;
        stk_cmd == PDS_STK_POP && !stk_busy
            |=> stack_pointer_reg == $past(stack_pointer_reg) - PDS_STACK_STEP && !stk_wr.valid;
    endproperty
    a_pop: assert property (p_pop) else $error("pop pointer");

    property p_sp_write;
        sp_wr_en && stk_cmd == PDS_STK_NONE && !stk_busy
            |=> stack_pointer_reg == ($past(sp_wr_data) & 16'hfffe);
    endproperty
    a_sp_write: assert property (p_sp_write) else $error("pointer write");
endmodule : pds_addr_gen_chk

bind pds_addr_gen pds_addr_gen_chk u_chk (.sys_clk(sys_clk), .reset(reset),
    .agu_req(agu_req), .agu_rsp(agu_rsp), .stk_cmd(stk_cmd), .pc_value(pc_value),
    .status_low_byte(status_low_byte), .sp_wr_en(sp_wr_en), .sp_wr_data(sp_wr_data),
    .stk_wr(stk_wr), .stk_busy(stk_busy), .stack_pointer_reg(stack_pointer_reg),
    .data_read_page_reg(data_read_page_reg));

`default_nettype wire

// ---- verif/paged_data_space_address_gen_tb.sv ----
// self-checking bench for the paged address generator
`timescale 1ns/1ps
`default_nettype none

module paged_data_space_address_gen_tb;
    import pds_pkg::*;

    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, status_low_byte;
    logic [31:0] pwdata, prdata;
    pds_req_s    agu_req;
    pds_rsp_s    agu_rsp;
    pds_stk_e    stk_cmd;
    pds_stk_wr_s stk_wr;
    logic [22:0] pc_value;
    logic        sp_wr_en, fp_wr_en, stk_busy, frame_pointer_active;
    logic [15:0] sp_wr_data, fp_wr_data, pop_addr, stack_pointer_reg, frame_pointer_reg;
    logic [9:0]  data_read_page_reg;
    logic [31:0] q;
    logic        e;
    int          fail_count, samples_checked, cycles;

    pds_addr_gen uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .agu_req(agu_req), .agu_rsp(agu_rsp), .stk_cmd(stk_cmd),
        .pc_value(pc_value), .status_low_byte(status_low_byte), .sp_wr_en(sp_wr_en),
        .sp_wr_data(sp_wr_data), .fp_wr_en(fp_wr_en), .fp_wr_data(fp_wr_data),
        .stk_wr(stk_wr), .stk_busy(stk_busy), .pop_addr(pop_addr),
        .stack_pointer_reg(stack_pointer_reg), .frame_pointer_reg(frame_pointer_reg),
        .data_read_page_reg(data_read_page_reg), .frame_pointer_active(frame_pointer_active));

    pds_mem_model u_mem (.sys_clk(sys_clk), .stk_wr(stk_wr));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0, q, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, q, e);
    endtask : wr

    task automatic agu(input pds_mode_e m, input logic w, input logic s, input logic [9:0] pg,
                       input logic [15:0] b, input logic [15:0] o, input logic [9:0] epg,
                       input logic [23:0] ea, input logic [15:0] ep, input logic [2:0] k);
        wr(PDS_OFS_PAGE, {22'h0, pg});
        agu_req <= '{1'b1, w, s, m, b, o};
        @(posedge sys_clk);
        agu_req.valid <= 1'b0;
        #1;
        chk("rsp valid", agu_rsp.valid, 1'b1);
        chk("page", data_read_page_reg, epg);
        chk("addr err", agu_rsp.addr_err, k[2]);
        if (k[0]) chk("addr", agu_rsp.addr, ea);
        if (k[1]) chk("new ptr", agu_rsp.new_ptr, ep);
        @(posedge sys_clk);
    endtask : agu

    // a pop lands while the push is busy and must be ignored
    task automatic push(input pds_stk_e c, input logic [22:0] pc, input logic [7:0] st);
        stk_cmd <= c; pc_value <= pc; status_low_byte <= st;
        @(posedge sys_clk);
        stk_cmd <= PDS_STK_POP;
        @(posedge sys_clk);
        stk_cmd <= PDS_STK_NONE;
        repeat (3) @(posedge sys_clk);
    endtask : push

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("page rst", data_read_page_reg, 10'h001);
        chk("sp rst", stack_pointer_reg, 16'h1000);
        rd(PDS_OFS_PAGE); chk("page rd", q, 32'h001);
        rd(PDS_OFS_SP); chk("sp rd", q, 32'h1000);
        rd(8'h20); chk("hole rd", q, 32'h0); chk("hole err", e, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_page();
        wr(PDS_OFS_PAGE, 32'h0); rd(PDS_OFS_PAGE); chk("clr", q, 32'h001);
        wr(PDS_OFS_PAGE, 32'h2ff); rd(PDS_OFS_PAGE); chk("set", q, 32'h2ff);
        wr(PDS_OFS_PAGE, 32'h0); rd(PDS_OFS_PAGE); chk("keep", q, 32'h2ff);
        wr(8'h20, 32'h5); chk("hole wr err", e, 1'b1);
        $display("test page done");
    endtask : t_page

    task automatic t_agu();
        agu(PDS_MODE_PLAIN, 0, 0, 10'h201, 16'h9234, 0, 10'h201, 24'h009234, 0, 1);
        agu(PDS_MODE_PLAIN, 0, 0, 10'h2ff, 16'hc000, 0, 10'h2ff, 24'h7fc000, 0, 1);
        agu(PDS_MODE_PLAIN, 0, 0, 10'h205, 16'h1234, 0, 10'h205, 24'h001234, 0, 1);
        agu(PDS_MODE_PLAIN, 1, 0, 10'h205, 16'h9000, 0, 10'h205, 0, 0, 4);
        agu(PDS_MODE_POST, 0, 0, 10'h205, 16'hfffe, 2, 10'h206, 24'h02fffe, 16'h8000, 3);
        agu(PDS_MODE_PRE, 0, 0, 10'h206, 16'h8000, 16'hfffe, 10'h205, 24'h02fffe, 16'hfffe, 3);
        agu(PDS_MODE_POST, 0, 0, 10'h2ff, 16'hfffe, 2, 10'h300, 24'h7ffffe, 16'h8000, 3);
        agu(PDS_MODE_PRE, 0, 0, 10'h300, 16'h8000, 16'hfffe, 10'h2ff, 24'h7ffffe, 16'hfffe, 3);
        agu(PDS_MODE_POST, 0, 0, 10'h3ff, 16'hfffe, 2, 10'h3ff, 24'hfffffe, 16'h0000, 3);
        agu(PDS_MODE_PRE, 0, 0, 10'h200, 16'h8000, 16'hfffe, 10'h200, 24'h007ffe, 16'h7ffe, 3);
        agu(PDS_MODE_PRE, 0, 0, 10'h001, 16'h8000, 16'hfffe, 10'h001, 24'h007ffe, 16'h7ffe, 3);
        agu(PDS_MODE_REGOFS, 0, 0, 10'h205, 16'hfffe, 2, 10'h205, 24'h28000, 16'h8000, 3);
        agu(PDS_MODE_MODULO, 0, 0, 10'h205, 16'hfffe, 2, 10'h205, 24'h28000, 16'h8000, 3);
        agu(PDS_MODE_BITREV, 0, 0, 10'h205, 16'hfffe, 2, 10'h205, 24'h28000, 16'h8000, 3);
        agu(PDS_MODE_PLAIN, 0, 0, 10'h205, 16'hfffe, 2, 10'h205, 24'h02fffe, 0, 1);
        agu(PDS_MODE_POST, 0, 0, 10'h205, 16'h7ffe, 2, 10'h205, 24'h007ffe, 16'h8000, 3);
        agu(PDS_MODE_POST, 0, 1, 10'h205, 16'hfffe, 2, 10'h205, 24'h00fffe, 16'h0000, 3);
        rd(PDS_OFS_STATUS); chk("pswr flag", q, 32'h2);
        $display("test agu done");
    endtask : t_agu

    task automatic t_stack();
        push(PDS_STK_CALL, 23'h5a1234, 8'hc3);
        chk("call lo", u_mem.mem[16'h1000], 16'h1234);
        chk("call hi", u_mem.mem[16'h1002], 16'h005a);
        chk("sp call", stack_pointer_reg, 16'h1004);
        push(PDS_STK_EXC, 23'h7fbeef, 8'ha5);
        chk("exc lo", u_mem.mem[16'h1004], 16'hbeef);
        chk("exc hi", u_mem.mem[16'h1006], 16'ha57f);
        stk_cmd <= PDS_STK_POP;
        @(posedge sys_clk);
        stk_cmd <= PDS_STK_NONE;
        @(posedge sys_clk);
        chk("sp pop", stack_pointer_reg, 16'h1006);
        chk("pop addr", pop_addr, 16'h1004);
        sp_wr_en <= 1'b1; sp_wr_data <= 16'h2001; fp_wr_en <= 1'b1; fp_wr_data <= 16'h3456;
        @(posedge sys_clk);
        sp_wr_en <= 1'b0; fp_wr_en <= 1'b0;
        @(posedge sys_clk);
        chk("sp wr", stack_pointer_reg, 16'h2000);
        chk("fp wr", frame_pointer_reg, 16'h3456);
        wr(PDS_OFS_SP, 32'h0123); rd(PDS_OFS_SP); chk("sp apb", q, 32'h0122);
        wr(PDS_OFS_CTRL, 32'h1); chk("fp mode", frame_pointer_active, 1'b1);
        $display("test stack done");
    endtask : t_stack

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("BAD t=%0t timeout", $time);
            give_verdict();
        end
    end

    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; agu_req = '0; agu_req.mode = PDS_MODE_PLAIN; stk_cmd = PDS_STK_NONE;
        pc_value = 23'h0; status_low_byte = 8'h00; sp_wr_en = 1'b0; sp_wr_data = 16'h0;
        fp_wr_en = 1'b0; fp_wr_data = 16'h0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_page();
        t_agu();
        t_stack();
        give_verdict();
    end
endmodule : paged_data_space_address_gen_tb

`default_nettype wire
